//--- logic/atpr_cfg.svh
// offsets, reset values and widths for the tuning parameter bank
`ifndef ATPR_CFG_SVH
`define ATPR_CFG_SVH
`define ATPR_ADDR_W 10
`define ATPR_DATA_W 8
`define ATPR_OFS_CLK_LOW 10'h100
`define ATPR_OFS_CLK_HIGH 10'h101
`define ATPR_OFS_IF_LOW 10'h102
`define ATPR_OFS_IF_HIGH 10'h103
`define ATPR_OFS_BW_LOW 10'h104
`define ATPR_OFS_BW_HIGH 10'h105
`define ATPR_OFS_TANK_L 10'h106
`define ATPR_OFS_MRGN_LOW 10'h107
`define ATPR_OFS_MRGN_UP 10'h108
`define ATPR_OFS_MRGN_TANK 10'h109
`define ATPR_OFS_CAL_CMD 10'h116
`define ATPR_RST_CLK_LOW 8'h10
`define ATPR_RST_CLK_HIGH 8'h0e
`define ATPR_RST_IF_LOW 8'h2c
`define ATPR_RST_IF_HIGH 8'h01
`define ATPR_RST_BW_LOW 8'h3c
`define ATPR_RST_BW_HIGH 8'h00
`define ATPR_RST_TANK_L 8'h14
`define ATPR_RST_MRGN_LOW 8'h05
`define ATPR_RST_MRGN_UP 8'h05
`define ATPR_RST_MRGN_TANK 8'h00
`define ATPR_RST_CAL_CMD 8'h00
`endif

//--- logic/atpr_pkg.sv
// types shared by the tuning parameter bank
package atpr_pkg;
  typedef logic [7:0] atpr_byte_type;
  typedef logic [9:0] atpr_addr_type;
endpackage

//--- logic/atpr_regs.sv
// tuning parameter register bank behind the control port
`timescale 1ns/1ps
`include "atpr_cfg.svh"
module atpr_regs
  import atpr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control port access, same clock
  input wire logic wr_en,
  input wire logic rd_en,
  input wire atpr_addr_type addr,
  input wire atpr_byte_type wr_data,
  output atpr_byte_type rd_data,
  output logic rd_hit,
  // software reset strobe from the control port
  input wire logic software_reset_bit,
  // calibration controller handshake
  input wire logic cal_end,
  output logic cal_busy,
  output atpr_byte_type cal_cmd,
  // parameter values for the calibration controller
  output logic [15:0] conv_clock_freq,
  output logic [15:0] if_centre_freq,
  output logic [15:0] bandwidth,
  output atpr_byte_type tank_inductance,
  output atpr_byte_type lower_resonator_margin,
  output atpr_byte_type upper_resonator_margin,
  output atpr_byte_type tank_resonator_margin
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  atpr_byte_type conv_clock_freq_low;
  atpr_byte_type conv_clock_freq_high;
  atpr_byte_type if_centre_freq_low;
  atpr_byte_type if_centre_freq_high;
  atpr_byte_type bandwidth_low;
  atpr_byte_type bandwidth_high;
  atpr_byte_type cal_cmd_reg;

  // write strobe for one offset
  function automatic logic hit_wr(input logic en, input atpr_addr_type a,
                                  input atpr_addr_type ofs);
    hit_wr = en && (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire logic we_clk_low = hit_wr(wr_en, addr, `ATPR_OFS_CLK_LOW);
  wire logic we_clk_high = hit_wr(wr_en, addr, `ATPR_OFS_CLK_HIGH);
  wire logic we_if_low = hit_wr(wr_en, addr, `ATPR_OFS_IF_LOW);
  wire logic we_if_high = hit_wr(wr_en, addr, `ATPR_OFS_IF_HIGH);
  wire logic we_bw_low = hit_wr(wr_en, addr, `ATPR_OFS_BW_LOW);
  wire logic we_bw_high = hit_wr(wr_en, addr, `ATPR_OFS_BW_HIGH);
  wire logic we_tank_l = hit_wr(wr_en, addr, `ATPR_OFS_TANK_L);
  wire logic we_mrgn_low = hit_wr(wr_en, addr, `ATPR_OFS_MRGN_LOW);
  wire logic we_mrgn_up = hit_wr(wr_en, addr, `ATPR_OFS_MRGN_UP);
  wire logic we_mrgn_tank = hit_wr(wr_en, addr, `ATPR_OFS_MRGN_TANK);
  wire logic we_cal_cmd = hit_wr(wr_en, addr, `ATPR_OFS_CAL_CMD);

  ////////////////////////////////////////////////////////////////////////////
  // parameter registers, one short process each, software reset restores defaults
  // converter clock frequency, low byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conv_clock_freq_low <= `ATPR_RST_CLK_LOW;
    end else if (software_reset_bit) begin
      conv_clock_freq_low <= `ATPR_RST_CLK_LOW;
    end else if (we_clk_low) begin
      conv_clock_freq_low <= wr_data;
    end
  end

  // converter clock frequency, high byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conv_clock_freq_high <= `ATPR_RST_CLK_HIGH;
    end else if (software_reset_bit) begin
      conv_clock_freq_high <= `ATPR_RST_CLK_HIGH;
    end else if (we_clk_high) begin
      conv_clock_freq_high <= wr_data;
    end
  end

  // if centre frequency, low byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      if_centre_freq_low <= `ATPR_RST_IF_LOW;
    end else if (software_reset_bit) begin
      if_centre_freq_low <= `ATPR_RST_IF_LOW;
    end else if (we_if_low) begin
      if_centre_freq_low <= wr_data;
    end
  end

  // if centre frequency, high byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      if_centre_freq_high <= `ATPR_RST_IF_HIGH;
    end else if (software_reset_bit) begin
      if_centre_freq_high <= `ATPR_RST_IF_HIGH;
    end else if (we_if_high) begin
      if_centre_freq_high <= wr_data;
    end
  end

  // bandwidth, low byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bandwidth_low <= `ATPR_RST_BW_LOW;
    end else if (software_reset_bit) begin
      bandwidth_low <= `ATPR_RST_BW_LOW;
    end else if (we_bw_low) begin
      bandwidth_low <= wr_data;
    end
  end

  // bandwidth, high byte, stored as written
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bandwidth_high <= `ATPR_RST_BW_HIGH;
    end else if (software_reset_bit) begin
      bandwidth_high <= `ATPR_RST_BW_HIGH;
    end else if (we_bw_high) begin
      bandwidth_high <= wr_data;
    end
  end

  // tank inductance
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tank_inductance <= `ATPR_RST_TANK_L;
    end else if (software_reset_bit) begin
      tank_inductance <= `ATPR_RST_TANK_L;
    end else if (we_tank_l) begin
      tank_inductance <= wr_data;
    end
  end

  // lower resonator margin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lower_resonator_margin <= `ATPR_RST_MRGN_LOW;
    end else if (software_reset_bit) begin
      lower_resonator_margin <= `ATPR_RST_MRGN_LOW;
    end else if (we_mrgn_low) begin
      lower_resonator_margin <= wr_data;
    end
  end

  // upper resonator margin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      upper_resonator_margin <= `ATPR_RST_MRGN_UP;
    end else if (software_reset_bit) begin
      upper_resonator_margin <= `ATPR_RST_MRGN_UP;
    end else if (we_mrgn_up) begin
      upper_resonator_margin <= wr_data;
    end
  end

  // tank resonator margin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tank_resonator_margin <= `ATPR_RST_MRGN_TANK;
    end else if (software_reset_bit) begin
      tank_resonator_margin <= `ATPR_RST_MRGN_TANK;
    end else if (we_mrgn_tank) begin
      tank_resonator_margin <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // calibration command, a new write wins over the end strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cal_cmd_reg <= `ATPR_RST_CAL_CMD;
    end else if (software_reset_bit) begin
      cal_cmd_reg <= `ATPR_RST_CAL_CMD;
    end else if (we_cal_cmd) begin
      cal_cmd_reg <= wr_data;
    end else if (cal_end) begin
      cal_cmd_reg <= `ATPR_RST_CAL_CMD;
    end
  end

  assign cal_cmd = cal_cmd_reg;
  assign cal_busy = |cal_cmd_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assembled 16-bit parameters, low byte in bits 7:0
  assign conv_clock_freq = {conv_clock_freq_high, conv_clock_freq_low};
  assign if_centre_freq = {if_centre_freq_high, if_centre_freq_low};
  // high byte is expected zero from software
  assign bandwidth = {bandwidth_high, bandwidth_low};

  ////////////////////////////////////////////////////////////////////////////
  // read mux, unmapped offsets return zero
  atpr_byte_type next_rd_data;
  logic next_rd_hit;
  always_comb begin
    next_rd_hit = 1'b1;
    unique case (addr)
      `ATPR_OFS_CLK_LOW: next_rd_data = conv_clock_freq_low;
      `ATPR_OFS_CLK_HIGH: next_rd_data = conv_clock_freq_high;
      `ATPR_OFS_IF_LOW: next_rd_data = if_centre_freq_low;
      `ATPR_OFS_IF_HIGH: next_rd_data = if_centre_freq_high;
      `ATPR_OFS_BW_LOW: next_rd_data = bandwidth_low;
      `ATPR_OFS_BW_HIGH: next_rd_data = bandwidth_high;
      `ATPR_OFS_TANK_L: next_rd_data = tank_inductance;
      `ATPR_OFS_MRGN_LOW: next_rd_data = lower_resonator_margin;
      `ATPR_OFS_MRGN_UP: next_rd_data = upper_resonator_margin;
      `ATPR_OFS_MRGN_TANK: next_rd_data = tank_resonator_margin;
      `ATPR_OFS_CAL_CMD: next_rd_data = cal_cmd_reg;
      default: begin
        next_rd_data = 8'h00;
        next_rd_hit = 1'b0;
      end
    endcase
  end

  // registered read data, one cycle after rd_en
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 8'h00;
      rd_hit <= 1'b0;
    end else if (rd_en) begin
      rd_data <= next_rd_data;
      rd_hit <= next_rd_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_clk_low_write: assert property (@(posedge clk) disable iff (!nrst)
    we_clk_low && !software_reset_bit |=> conv_clock_freq[7:0] == $past(wr_data))
    else $error("clock low byte not stored");
  a_clk_high_write: assert property (@(posedge clk) disable iff (!nrst)
    we_clk_high && !software_reset_bit |=> conv_clock_freq[15:8] == $past(wr_data))
    else $error("clock high byte not stored");
  a_clk_default: assert property (@(posedge clk) disable iff (!nrst)
    software_reset_bit |=> conv_clock_freq == 16'h0e10)
    else $error("clock default wrong");
  a_if_default: assert property (@(posedge clk) disable iff (!nrst)
    software_reset_bit |=> if_centre_freq == 16'h012c)
    else $error("if default wrong");
  a_bw_default: assert property (@(posedge clk) disable iff (!nrst)
    software_reset_bit |=> bandwidth == 16'h003c)
    else $error("bandwidth default wrong");
  a_tank_default: assert property (@(posedge clk) disable iff (!nrst)
    software_reset_bit |=> tank_inductance == 8'h14)
    else $error("inductance default wrong");
  a_margin_default: assert property (@(posedge clk) disable iff (!nrst)
    software_reset_bit |=> lower_resonator_margin == 8'h05 &&
      upper_resonator_margin == 8'h05 && tank_resonator_margin == 8'h00)
    else $error("margin default wrong");
  a_margin_hold: assert property (@(posedge clk) disable iff (!nrst)
    !wr_en && !software_reset_bit |=> $stable(tank_resonator_margin) &&
      $stable(upper_resonator_margin) && $stable(lower_resonator_margin))
    else $error("margin changed without write");
  a_cal_self_clear: assert property (@(posedge clk) disable iff (!nrst)
    cal_end && !we_cal_cmd |=> !cal_busy)
    else $error("calibration command not cleared");
  a_read_back: assert property (@(posedge clk) disable iff (!nrst)
    we_tank_l && !software_reset_bit ##1 rd_en && addr == `ATPR_OFS_TANK_L
      |=> rd_data == $past(wr_data, 2) && rd_hit)
    else $error("read back mismatch");
  // every byte written without software reset lands unmodified
  a_if_low_write: assert property (@(posedge clk) disable iff (!nrst)
    we_if_low && !software_reset_bit |=> if_centre_freq[7:0] == $past(wr_data))
    else $error("if low byte not stored");
  a_if_high_write: assert property (@(posedge clk) disable iff (!nrst)
    we_if_high && !software_reset_bit |=> if_centre_freq[15:8] == $past(wr_data))
    else $error("if high byte not stored");
  a_bw_low_write: assert property (@(posedge clk) disable iff (!nrst)
    we_bw_low && !software_reset_bit |=> bandwidth[7:0] == $past(wr_data))
    else $error("bandwidth low byte not stored");
  a_bw_high_write: assert property (@(posedge clk) disable iff (!nrst)
    we_bw_high && !software_reset_bit |=> bandwidth[15:8] == $past(wr_data))
    else $error("bandwidth high byte not stored");
  a_tank_write: assert property (@(posedge clk) disable iff (!nrst)
    we_tank_l && !software_reset_bit |=> tank_inductance == $past(wr_data))
    else $error("inductance not stored");
  a_lower_margin_write: assert property (@(posedge clk) disable iff (!nrst)
    we_mrgn_low && !software_reset_bit |=> lower_resonator_margin == $past(wr_data))
    else $error("lower margin not stored");
  a_upper_margin_write: assert property (@(posedge clk) disable iff (!nrst)
    we_mrgn_up && !software_reset_bit |=> upper_resonator_margin == $past(wr_data))
    else $error("upper margin not stored");
  a_tank_margin_write: assert property (@(posedge clk) disable iff (!nrst)
    we_mrgn_tank && !software_reset_bit |=> tank_resonator_margin == $past(wr_data))
    else $error("tank margin not stored");
  a_reset_over_write: assert property (@(posedge clk) disable iff (!nrst)
    software_reset_bit && wr_en |=> if_centre_freq == 16'h012c &&
      tank_inductance == 8'h14 && cal_cmd == 8'h00)
    else $error("write not lost under software reset");
  a_reset_release: assert property (@(posedge clk)
    $rose(nrst) |-> conv_clock_freq == 16'h0e10 && if_centre_freq == 16'h012c &&
      bandwidth == 16'h003c && !cal_busy && !rd_hit)
    else $error("defaults missing after reset");
  a_cal_write_wins: assert property (@(posedge clk) disable iff (!nrst)
    we_cal_cmd && !software_reset_bit |=> cal_cmd == $past(wr_data))
    else $error("calibration command write lost");
  a_read_hold: assert property (@(posedge clk) disable iff (!nrst)
    !rd_en |=> $stable(rd_data) && $stable(rd_hit))
    else $error("read data changed without read");

  c_write_clock: cover property (@(posedge clk) disable iff (!nrst) we_clk_high);
  c_soft_reset: cover property (@(posedge clk) disable iff (!nrst) software_reset_bit);
  c_cal_cycle: cover property (@(posedge clk) disable iff (!nrst)
    we_cal_cmd ##[1:20] cal_end);
  c_unmapped_read: cover property (@(posedge clk) disable iff (!nrst)
    rd_en && !next_rd_hit);

endmodule

//--- sim/atpr_tb.sv
// self-checking bench for the tuning parameter register bank
`timescale 1ns/1ps
module testbench;
  import atpr_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  atpr_addr_type addr = 10'h000;
  atpr_byte_type wr_data = 8'h00;
  logic software_reset_bit = 1'b0;
  logic cal_end = 1'b0;
  atpr_byte_type rd_data, cal_cmd, tank_inductance;
  atpr_byte_type lower_resonator_margin, upper_resonator_margin, tank_resonator_margin;
  logic rd_hit, cal_busy;
  logic [15:0] conv_clock_freq, if_centre_freq, bandwidth;
  int failures = 0;
  int tests_run = 0;
  atpr_byte_type dflt [10] = '{8'h10, 8'h0e, 8'h2c, 8'h01, 8'h3c, 8'h00, 8'h14, 8'h05,
    8'h05, 8'h00};
  atpr_byte_type d;
  logic h;
  ////////////////////////////////////////////////////////////////////////////////
  // design under test
  atpr_regs dut (.clk(clk), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data), .rd_hit(rd_hit),
    .software_reset_bit(software_reset_bit), .cal_end(cal_end), .cal_busy(cal_busy),
    .cal_cmd(cal_cmd), .conv_clock_freq(conv_clock_freq), .if_centre_freq(if_centre_freq),
    .bandwidth(bandwidth), .tank_inductance(tank_inductance),
    .lower_resonator_margin(lower_resonator_margin),
    .upper_resonator_margin(upper_resonator_margin),
    .tank_resonator_margin(tank_resonator_margin));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and run end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // compare one result, bytes and flags zero extended
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one write strobe, taken at the second edge
  task automatic wr(input atpr_addr_type a, input atpr_byte_type v);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // one read strobe, answer sampled after the following edge
  task automatic rd(input atpr_addr_type a, output atpr_byte_type v, output logic hit);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
    hit = rd_hit;
  endtask
  // write pattern, complemented on the second pass, bandwidth high byte kept zero
  function automatic atpr_byte_type pat(input int p, input int i);
    pat = (i == 5) ? 8'h00 : (8'ha5 ^ 8'(i)) ^ (p != 0 ? 8'hff : 8'h00);
  endfunction
  // all parameter registers and parameter outputs at their defaults
  task automatic check_defaults();
    for (int i = 0; i < 10; i++) begin
      rd(10'(10'h100 + i), d, h);
      chk({8'h00, d}, {8'h00, dflt[i]});
      chk({15'h0000, h}, 16'h0001);
    end
    chk(conv_clock_freq, 16'h0e10);
    chk(if_centre_freq, 16'h012c);
    chk(bandwidth, 16'h003c);
    chk({tank_inductance, lower_resonator_margin}, 16'h1405);
    chk({upper_resonator_margin, tank_resonator_margin}, 16'h0500);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    check_defaults();
    $display("test reset values done");
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 10; i++) wr(10'(10'h100 + i), pat(p, i));
      for (int i = 0; i < 10; i++) begin
        rd(10'(10'h100 + i), d, h);
        chk({8'h00, d}, {8'h00, pat(p, i)});
      end
      chk(conv_clock_freq, {pat(p, 1), pat(p, 0)});
      chk(if_centre_freq, {pat(p, 3), pat(p, 2)});
      chk(bandwidth, {pat(p, 5), pat(p, 4)});
      chk({tank_inductance, lower_resonator_margin}, {pat(p, 6), pat(p, 7)});
      chk({upper_resonator_margin, tank_resonator_margin}, {pat(p, 8), pat(p, 9)});
    end
    $display("test write readback done");
    wr(10'h10a, 8'hff);
    rd(10'h10a, d, h);
    chk({7'h00, h, d}, 16'h0000);
    rd(10'h0ff, d, h);
    chk({7'h00, h, d}, 16'h0000);
    $display("test unmapped done");
    // write then read of the same byte on the next cycle
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= 10'h106;
    wr_data <= 8'h33;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk({8'h00, tank_inductance}, 16'h0033);
    chk({7'h00, rd_hit, rd_data}, 16'h0133);
    $display("test back to back done");
    @(posedge clk);
    software_reset_bit <= 1'b1;
    wr_en <= 1'b1;
    addr <= 10'h106;
    wr_data <= 8'h77;
    @(posedge clk);
    software_reset_bit <= 1'b0;
    wr_en <= 1'b0;
    check_defaults();
    $display("test software reset done");
    wr(10'h116, 8'h01);
    #1;
    chk({7'h00, cal_busy, cal_cmd}, 16'h0101);
    rd(10'h116, d, h);
    chk({7'h00, h, d}, 16'h0101);
    repeat (3) @(posedge clk);
    chk({15'h0000, cal_busy}, 16'h0001);
    cal_end <= 1'b1;
    @(posedge clk);
    cal_end <= 1'b0;
    #1;
    chk({7'h00, cal_busy, cal_cmd}, 16'h0000);
    // a write in the cycle of the end strobe wins
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= 10'h116;
    wr_data <= 8'h02;
    cal_end <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    cal_end <= 1'b0;
    #1;
    chk({7'h00, cal_busy, cal_cmd}, 16'h0102);
    // software reset clears a pending command
    @(posedge clk);
    software_reset_bit <= 1'b1;
    @(posedge clk);
    software_reset_bit <= 1'b0;
    #1;
    chk({7'h00, cal_busy, cal_cmd}, 16'h0000);
    $display("test calibration command done");
    end_sim();
  end
endmodule
